// >>> pmcc_counter.v
// one programmable 48-bit monitoring counter with its control register
`include "pmcc_regs.vh"
module pmcc_counter (
    input  wire        clk,
    input  wire        resetn,
    input  wire        ctl_we,
    input  wire        lo_we,
    input  wire        hi_we,
    input  wire [31:0] wdata,
    input  wire        clr_ctl,
    input  wire        clr_cnt,
    input  wire        run,
    input  wire [15:0] lines,
    input  wire        filt_ok,
    output reg  [31:0] ctl_r,
    output reg  [47:0] cnt_r,
    output reg         wrap_r
);
    reg  [3:0]  sel;
    reg  [2:0]  inc;
    reg         prev_r;
    wire [7:0]  evt      = ctl_r[`PMCC_F_EVT];
    wire [7:0]  thr      = ctl_r[`PMCC_F_THR];
    wire [3:0]  masked   = sel & ctl_r[11:8];
    wire [2:0]  raw      = {2'b00, masked[0]} + {2'b00, masked[1]}
                         + {2'b00, masked[2]} + {2'b00, masked[3]};
    wire        ge       = {5'h00, raw} >= thr;
    wire        cond     = ctl_r[`PMCC_B_INV] ? ~ge : ge;
    wire        counting = run & ctl_r[`PMCC_B_EN];
    wire [48:0] sum      = {1'b0, cnt_r} + {46'h0, inc};
    wire        sw_write = clr_cnt | lo_we | hi_we;

    always @* begin
        case (evt)
            `PMCC_EVT_G0: sel = lines[3:0];
            `PMCC_EVT_G1: sel = lines[7:4];
            `PMCC_EVT_G2: sel = lines[11:8];
            `PMCC_EVT_G3: sel = lines[15:12];
            default:      sel = 4'h0;
        endcase
        if (!filt_ok) begin
            inc = 3'h0;
        end else if (thr == 8'h00) begin
            inc = raw;
        end else if (ctl_r[`PMCC_B_EDGE]) begin
            inc = {2'b00, cond & ~prev_r};
        end else begin
            inc = {2'b00, cond};
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctl_r  <= `PMCC_Z32;
            cnt_r  <= `PMCC_Z48;
            wrap_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            prev_r <= cond;
            if (clr_ctl) begin
                ctl_r <= `PMCC_Z32;
            end else if (ctl_we) begin
                ctl_r <= wdata & `PMCC_CTL_MASK;
            end
            // software writes take precedence over a count in the same cycle
            if (clr_cnt) begin
                cnt_r <= `PMCC_Z48;
            end else if (lo_we) begin
                cnt_r[31:0] <= wdata;
            end else if (hi_we) begin
                cnt_r[47:32] <= wdata[15:0];
            end else if (counting) begin
                cnt_r <= sum[47:0];
            end
            wrap_r <= counting & ~sw_write & sum[48];
        end
    end
endmodule // pmcc_counter

// >>> pmcc_ctrl.v
// perf monitor counter control: global, two boxes and configuration hub
`include "pmcc_regs.vh"
module pmcc_ctrl (
    input  wire        clk,
    input  wire        resetn,
    input  wire        cfg_wr,
    input  wire        cfg_rd,
    input  wire [11:0] cfg_addr,
    input  wire [31:0] cfg_wdata,
    output reg  [31:0] cfg_rdata_r,
    output reg         cfg_rvalid_r,
    input  wire [47:0] event_lines,
    input  wire [15:0] box_opcode,
    input  wire [2:0]  local_node_number,
    input  wire [23:0] node_group_map,
    output reg         pmi_r,
    output reg  [3:0]  pmi_core_r
);
    wire [3:0]   unit = cfg_addr[11:8];
    wire [7:0]   off  = cfg_addr[7:0];
    // box picked by a read; kept apart from the clocked loop variable
    wire         rbox = (unit == `PMCC_UNIT_BOX1);

    // global state
    reg  [3:0]   core_r;
    reg          wfrz_r;
    reg          ghalt_r;
    reg  [3:0]   gstat_r;
    // box state, two boxes
    reg  [1:0]   bhalt_r;
    reg  [17:0]  filt_r;
    reg  [7:0]   bstat_r;
    // hub state
    reg  [2:0]   hstat_r;
    reg  [31:0]  fctl_r;
    reg  [47:0]  fcnt_r;
    reg          fwrap_r;
    reg  [31:0]  rd_nxt;

    wire [`PMCC_NCTR*32-1:0] ctl_all;
    wire [`PMCC_NCTR*48-1:0] cnt_all;
    wire [`PMCC_NCTR-1:0]    wrap;
    wire [`PMCC_NCTR-1:0]    notify;
    wire [`PMCC_NCTR-1:0]    hit_ctl;
    wire [`PMCC_NCTR-1:0]    hit_lo;
    wire [`PMCC_NCTR-1:0]    hit_hi;

    wire glb_wr   = cfg_wr & (unit == `PMCC_UNIT_GLB);
    wire gctl_wr  = glb_wr & (off == `PMCC_OFF_GCTL);
    wire gstat_wr = glb_wr & (off == `PMCC_OFF_GSTAT);
    wire [1:0] bctl_wr;
    wire [1:0] filt_wr;
    wire [1:0] bst0_wr;
    wire [1:0] bst1_wr;
    wire hub_wr   = cfg_wr & (unit == `PMCC_UNIT_HUB);
    wire hst_wr   = hub_wr & (off == `PMCC_OFF_BSTAT0);
    wire fctl_wr  = hub_wr & (off == `PMCC_OFF_FCTL);
    wire flo_wr   = hub_wr & (off == `PMCC_OFF_FDLO);
    wire fhi_wr   = hub_wr & (off == `PMCC_OFF_FDHI);

    assign bctl_wr[0] = cfg_wr & (unit == `PMCC_UNIT_BOX0) & (off == `PMCC_OFF_BCTL);
    assign bctl_wr[1] = cfg_wr & (unit == `PMCC_UNIT_BOX1) & (off == `PMCC_OFF_BCTL);
    assign filt_wr[0] = cfg_wr & (unit == `PMCC_UNIT_BOX0) & (off == `PMCC_OFF_FILT);
    assign filt_wr[1] = cfg_wr & (unit == `PMCC_UNIT_BOX1) & (off == `PMCC_OFF_FILT);
    assign bst0_wr[0] = cfg_wr & (unit == `PMCC_UNIT_BOX0) & (off == `PMCC_OFF_BSTAT0);
    assign bst0_wr[1] = cfg_wr & (unit == `PMCC_UNIT_BOX1) & (off == `PMCC_OFF_BSTAT0);
    assign bst1_wr[0] = cfg_wr & (unit == `PMCC_UNIT_BOX0) & (off == `PMCC_OFF_BSTAT1);
    assign bst1_wr[1] = cfg_wr & (unit == `PMCC_UNIT_BOX1) & (off == `PMCC_OFF_BSTAT1);

    // counters 0..3 in box 0, 4..7 in box 1, 8..9 in the hub
    genvar k;
    generate
        for (k = 0; k < `PMCC_NCTR; k = k + 1) begin : g_ctr
            localparam integer BOX  = k / 4;
            localparam integer SLOT = k % 4;
            localparam [3:0]   UN   = (k < 4) ? `PMCC_UNIT_BOX0 :
                                      ((k < 8) ? `PMCC_UNIT_BOX1 : `PMCC_UNIT_HUB);
            localparam integer CO_I = `PMCC_OFF_CTL + SLOT * `PMCC_CTL_STEP;
            localparam integer DO_I = `PMCC_OFF_DATA + SLOT * `PMCC_DATA_STEP;
            localparam [7:0]   CO   = CO_I[7:0];
            localparam [7:0]   DO   = DO_I[7:0];
            localparam [7:0]   HO   = DO + `PMCC_HI_STEP;
            wire run;
            wire clr_ctl;
            wire clr_cnt;
            wire filt_ok;
            assign hit_ctl[k] = (unit == UN) & (off == CO);
            assign hit_lo[k]  = (unit == UN) & (off == DO);
            assign hit_hi[k]  = (unit == UN) & (off == HO);
            if (k < 8) begin : g_box
                assign run     = ~ghalt_r & ~bhalt_r[BOX];
                assign clr_ctl = bctl_wr[BOX] & cfg_wdata[`PMCC_B_RSTCTL];
                assign clr_cnt = bctl_wr[BOX] & cfg_wdata[`PMCC_B_RSTCNT];
                assign filt_ok = ~filt_r[BOX*9+8] |
                                 (box_opcode[BOX*8+:8] == filt_r[BOX*9+:8]);
            end else begin : g_hub
                // no box level halt or unit reset in the hub
                assign run     = ~ghalt_r;
                assign clr_ctl = 1'b0;
                assign clr_cnt = 1'b0;
                assign filt_ok = 1'b1;
            end
            pmcc_counter u_ctr (
                .clk     (clk),
                .resetn  (resetn),
                .ctl_we  (cfg_wr & hit_ctl[k]),
                .lo_we   (cfg_wr & hit_lo[k]),
                .hi_we   (cfg_wr & hit_hi[k]),
                .wdata   (cfg_wdata),
                .clr_ctl (clr_ctl),
                .clr_cnt (clr_cnt),
                .run     (run),
                .lines   (event_lines[BOX*16+:16]),
                .filt_ok (filt_ok),
                .ctl_r   (ctl_all[k*32+:32]),
                .cnt_r   (cnt_all[k*48+:48]),
                .wrap_r  (wrap[k])
            );
            assign notify[k] = wrap[k] & ctl_all[k*32+`PMCC_B_NOTIFY];
        end
    endgenerate

    wire        fnotify   = fwrap_r & fctl_r[`PMCC_B_NOTIFY];
    wire        any_note  = (|notify) | fnotify;
    wire        fcount    = fctl_r[`PMCC_B_EN] & ~ghalt_r;
    wire [48:0] fsum      = {1'b0, fcnt_r} + {1'b0, `PMCC_ONE48};
    wire        fsw       = flo_wr | fhi_wr;
    wire [3:0]  gset      = {fnotify, |notify[9:8], |notify[7:4], |notify[3:0]};

    // global control, global halt and global status
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            core_r  <= 4'h0;
            wfrz_r  <= 1'b0;
            ghalt_r <= 1'b0;
            gstat_r <= 4'h0;
        end else begin
            if (gctl_wr) begin
                core_r <= cfg_wdata[`PMCC_F_CORE];
                wfrz_r <= cfg_wdata[`PMCC_B_WFRZ];
            end
            // halt wins over resume so a wrap freeze is never dropped
            if ((gctl_wr & cfg_wdata[`PMCC_B_HALT]) | (wfrz_r & any_note)) begin
                ghalt_r <= 1'b1;
            end else if (gctl_wr & cfg_wdata[`PMCC_B_RESUME]) begin
                ghalt_r <= 1'b0;
            end
            gstat_r <= (gstat_r & ~(gstat_wr ? cfg_wdata[3:0] : 4'h0)) | gset;
        end
    end

    // box halt, filter and per-block status; set wins over clear
    integer b;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bhalt_r <= 2'b00;
            filt_r  <= 18'h00000;
            bstat_r <= 8'h00;
        end else begin
            for (b = 0; b < 2; b = b + 1) begin
                if (bctl_wr[b]) begin
                    bhalt_r[b] <= cfg_wdata[`PMCC_B_BHALT];
                end
                if (filt_wr[b]) begin
                    filt_r[b*9+:9] <= cfg_wdata[8:0];
                end
                bstat_r[b*4+:2] <= (bstat_r[b*4+:2]
                                    & ~(bst0_wr[b] ? cfg_wdata[1:0] : 2'b00))
                                   | wrap[b*4+:2];
                bstat_r[b*4+2+:2] <= (bstat_r[b*4+2+:2]
                                      & ~(bst1_wr[b] ? cfg_wdata[1:0] : 2'b00))
                                     | wrap[b*4+2+:2];
            end
        end
    end

    // hub fixed counter and hub status
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fctl_r  <= `PMCC_Z32;
            fcnt_r  <= `PMCC_Z48;
            fwrap_r <= 1'b0;
            hstat_r <= 3'h0;
        end else begin
            if (fctl_wr) begin
                fctl_r <= cfg_wdata & `PMCC_FCTL_MASK;
            end
            if (flo_wr) begin
                fcnt_r[31:0] <= cfg_wdata;
            end else if (fhi_wr) begin
                fcnt_r[47:32] <= cfg_wdata[15:0];
            end else if (fcount) begin
                fcnt_r <= fsum[47:0];
            end
            fwrap_r <= fcount & ~fsw & fsum[48];
            hstat_r <= (hstat_r & ~(hst_wr ? cfg_wdata[2:0] : 3'h0))
                       | {fwrap_r, wrap[9:8]};
        end
    end

    // monitoring interrupt toward the selected core
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pmi_r      <= 1'b0;
            pmi_core_r <= 4'h0;
        end else begin
            pmi_r <= any_note;
            if (any_note) begin
                pmi_core_r <= core_r;
            end
        end
    end

    // read path; reads have no side effects on counts or flags
    integer i;
    always @* begin
        rd_nxt = `PMCC_Z32;
        case (unit)
            `PMCC_UNIT_GLB: begin
                if (off == `PMCC_OFF_GCTL) begin
                    rd_nxt = {21'h0, wfrz_r, 1'b0, ghalt_r, 4'h0, core_r};
                end else if (off == `PMCC_OFF_GSTAT) begin
                    rd_nxt = {28'h0, gstat_r};
                end
            end
            `PMCC_UNIT_BOX0, `PMCC_UNIT_BOX1: begin
                if (off == `PMCC_OFF_BCTL) begin
                    rd_nxt = {23'h0, bhalt_r[rbox], 8'h00};
                end else if (off == `PMCC_OFF_BSTAT0) begin
                    rd_nxt = {30'h0, (rbox ? bstat_r[5:4] : bstat_r[1:0])};
                end else if (off == `PMCC_OFF_BSTAT1) begin
                    rd_nxt = {30'h0, (rbox ? bstat_r[7:6] : bstat_r[3:2])};
                end else if (off == `PMCC_OFF_FILT) begin
                    rd_nxt = {23'h0, (rbox ? filt_r[17:9] : filt_r[8:0])};
                end
            end
            `PMCC_UNIT_HUB: begin
                if (off == `PMCC_OFF_BSTAT0) begin
                    rd_nxt = {29'h0, hstat_r};
                end else if (off == `PMCC_OFF_FCTL) begin
                    rd_nxt = fctl_r;
                end else if (off == `PMCC_OFF_FDLO) begin
                    rd_nxt = fcnt_r[31:0];
                end else if (off == `PMCC_OFF_FDHI) begin
                    rd_nxt = {16'h0000, fcnt_r[47:32]};
                end else if (off == `PMCC_OFF_NODE) begin
                    rd_nxt = {29'h0, local_node_number};
                end else if (off == `PMCC_OFF_GMAP) begin
                    rd_nxt = {8'h00, node_group_map};
                end
            end
            default: rd_nxt = `PMCC_Z32;
        endcase
        for (i = 0; i < `PMCC_NCTR; i = i + 1) begin
            if (hit_ctl[i]) begin
                rd_nxt = ctl_all[i*32+:32];
            end else if (hit_lo[i]) begin
                rd_nxt = cnt_all[i*48+:32];
            end else if (hit_hi[i]) begin
                rd_nxt = {16'h0000, cnt_all[i*48+32+:16]};
            end
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_rdata_r  <= `PMCC_Z32;
            cfg_rvalid_r <= 1'b0;
        end else begin
            cfg_rvalid_r <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata_r <= rd_nxt;
            end
        end
    end
endmodule // pmcc_ctrl

// >>> pmcc_ctrl_assertions.sv
// port-level concurrent checks for the perf monitor counter control
module pmcc_ctrl_assertions (
    input wire        clk,
    input wire        resetn,
    input wire        cfg_wr,
    input wire        cfg_rd,
    input wire [11:0] cfg_addr,
    input wire [31:0] cfg_wdata,
    input wire [31:0] cfg_rdata_r,
    input wire        cfg_rvalid_r,
    input wire [2:0]  local_node_number,
    input wire [23:0] node_group_map,
    input wire        pmi_r,
    input wire [3:0]  pmi_core_r
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] core_s_r;
    logic       wr_seen_r;
    wire        gctl_wr;
    assign gctl_wr = cfg_wr && cfg_addr == 12'h400;
    // shadow of the target core, so the interrupt target can be judged
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            core_s_r  <= 4'h0;
            wr_seen_r <= 1'b0;
        end else begin
            if (gctl_wr) begin
                core_s_r <= cfg_wdata[3:0];
            end
            if (cfg_wr) begin
                wr_seen_r <= 1'b1;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_read_answer: assert property (cfg_rd |=> cfg_rvalid_r)
        else $error("read got no answer");
    a_answer_cause: assert property (cfg_rvalid_r |-> $past(cfg_rd))
        else $error("answer without read");
    a_data_hold: assert property (!$past(cfg_rd) |-> $stable(cfg_rdata_r))
        else $error("read data moved without read");
    a_node_read: assert property (cfg_rd && cfg_addr == 12'h0C0 |=>
        cfg_rdata_r == {29'h0000000, $past(local_node_number)})
        else $error("node number read wrong");
    a_map_read: assert property (cfg_rd && cfg_addr == 12'h0D4 |=>
        cfg_rdata_r == {8'h00, $past(node_group_map)})
        else $error("node map read wrong");
    a_ctl_reserved: assert property (cfg_rd && cfg_addr[11:4] inside {8'h11, 8'h21} |=>
        (cfg_rdata_r & 32'h002B0000) == 32'h00000000)
        else $error("reserved control bits read nonzero");
    a_gstat_unused: assert property (cfg_rd && cfg_addr == 12'h404 |=>
        cfg_rdata_r[31:4] == 28'h0000000)
        else $error("global status spare bits set");
    a_core_target: assert property (pmi_r && !$past(gctl_wr) && !$past(gctl_wr, 2) |->
        pmi_core_r == core_s_r)
        else $error("interrupt sent to wrong core");
    a_core_hold: assert property (!pmi_r |-> $stable(pmi_core_r))
        else $error("target core moved without interrupt");
    a_idle_reset: assert property (!wr_seen_r |-> !pmi_r)
        else $error("interrupt before any setup");
    c_pmi: cover property (pmi_r);
    c_map: cover property (cfg_rd && cfg_addr == 12'h0D4);
    c_both: cover property (cfg_rvalid_r && cfg_rdata_r == 32'h00000003);
endmodule // pmcc_ctrl_assertions

bind pmcc_ctrl pmcc_ctrl_assertions u_pmcc_ctrl_assertions (
    .clk(clk), .resetn(resetn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_r(cfg_rdata_r),
    .cfg_rvalid_r(cfg_rvalid_r), .local_node_number(local_node_number),
    .node_group_map(node_group_map), .pmi_r(pmi_r), .pmi_core_r(pmi_core_r)
);

// >>> pmcc_regs.vh
// register map, field positions and constants of the perf monitor counter control
`ifndef PMCC_REGS_VH
`define PMCC_REGS_VH

`define PMCC_AW          12
`define PMCC_CW          48
`define PMCC_NCTR        10
`define PMCC_UNIT_HUB    4'h0
`define PMCC_UNIT_BOX0   4'h1
`define PMCC_UNIT_BOX1   4'h2
`define PMCC_UNIT_GLB    4'h4
`define PMCC_OFF_GCTL    8'h00
`define PMCC_OFF_GSTAT   8'h04
`define PMCC_OFF_BCTL    8'h00
`define PMCC_OFF_BSTAT0  8'h04
`define PMCC_OFF_FILT    8'h08
`define PMCC_OFF_BSTAT1  8'h0C
`define PMCC_OFF_CTL     8'h10
`define PMCC_CTL_STEP    8'h04
`define PMCC_OFF_DATA    8'h20
`define PMCC_DATA_STEP   8'h08
`define PMCC_HI_STEP     8'h04
`define PMCC_OFF_FCTL    8'h40
`define PMCC_OFF_FDLO    8'h48
`define PMCC_OFF_FDHI    8'h4C
`define PMCC_OFF_NODE    8'hC0
`define PMCC_OFF_GMAP    8'hD4
`define PMCC_F_EVT       7:0
`define PMCC_F_SUB       15:8
`define PMCC_B_EDGE      18
`define PMCC_B_NOTIFY    20
`define PMCC_B_EN        22
`define PMCC_B_INV       23
`define PMCC_F_THR       31:24
`define PMCC_CTL_MASK    32'hFFD4FFFF
`define PMCC_FCTL_MASK   32'h00500000
`define PMCC_F_CORE      3:0
`define PMCC_B_HALT      8
`define PMCC_B_RESUME    9
`define PMCC_B_WFRZ      10
`define PMCC_B_RSTCTL    0
`define PMCC_B_RSTCNT    1
`define PMCC_B_BHALT     8
`define PMCC_F_OPC       7:0
`define PMCC_B_FEN       8
`define PMCC_EVT_NONE    8'h00
`define PMCC_EVT_G0      8'h01
`define PMCC_EVT_G1      8'h02
`define PMCC_EVT_G2      8'h03
`define PMCC_EVT_G3      8'h04
`define PMCC_Z32         32'h00000000
`define PMCC_Z48         48'h000000000000
`define PMCC_ONE48       48'h000000000001

`endif

// >>> testbench.sv
// self-checking bench for the perf monitor counter control
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk;
    logic        resetn;
    logic        cfg_wr;
    logic        cfg_rd;
    logic [11:0] cfg_addr;
    logic [31:0] cfg_wdata;
    logic [31:0] cfg_rdata_r;
    logic        cfg_rvalid_r;
    logic [47:0] event_lines;
    logic [15:0] box_opcode;
    logic [2:0]  local_node_number;
    logic [23:0] node_group_map;
    logic        pmi_r;
    logic [3:0]  pmi_core_r;
    integer      n_errors;
    integer      checks_done;
    integer      i;
    logic [31:0] v;

    pmcc_ctrl u_pmcc_ctrl (
        .clk(clk), .resetn(resetn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_r(cfg_rdata_r),
        .cfg_rvalid_r(cfg_rvalid_r), .event_lines(event_lines), .box_opcode(box_opcode),
        .local_node_number(local_node_number), .node_group_map(node_group_map),
        .pmi_r(pmi_r), .pmi_core_r(pmi_core_r)
    );

    always #5 clk = ~clk;

    task wrap_up;
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input string nm, input [31:0] e, input [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask

    // every access starts a cycle after the last, so strobes never toggle twice
    task wr(input [11:0] a, input [31:0] d);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask

    task rd(input [11:0] a, output [31:0] d);
        integer k;
        @(negedge clk);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge clk);
        cfg_rd = 1'b0;
        for (k = 0; k < 4 && cfg_rvalid_r !== 1'b1; k++) @(negedge clk);
        if (cfg_rvalid_r !== 1'b1) begin
            n_errors++;
            wrap_up();
        end else d = cfg_rdata_r;
    endtask

    task rc(input [11:0] a, input [31:0] e);
        rd(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask

    // two reads taken two edges apart: difference is the count rate times two
    task rdiff(input [11:0] a, input [31:0] e);
        logic [31:0] x;
        rd(a, x);
        rd(a, v);
        chk($sformatf("step %h", a), e, v - x);
    endtask

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 12'h000;
        cfg_wdata = 32'h00000000;
        event_lines = 48'hFFFFFFFFFFFF;
        box_opcode = 16'h0000;
        local_node_number = 3'h5;
        node_group_map = 24'hFAC688;
        n_errors = 0;
        checks_done = 0;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        rc(12'h110, 32'h00000000);
        rc(12'h120, 32'h00000000);
        rc(12'h040, 32'h00000000);
        rc(12'h048, 32'h00000000);
        rc(12'h0C0, 32'h00000005);
        rc(12'h0D4, 32'h00FAC688);
        wr(12'h0C0, 32'h00000007);
        rc(12'h0C0, 32'h00000005);
        rc(12'h300, 32'h00000000);
        wr(12'h010, 32'h00400000);
        rdiff(12'h020, 32'h00000000);
        wr(12'h010, 32'h00400F01);
        rdiff(12'h020, 32'h00000008);
        wr(12'h040, 32'h00400000);
        rdiff(12'h048, 32'h00000002);
        wr(12'h400, 32'h00000100);
        rdiff(12'h048, 32'h00000000);
        wr(12'h400, 32'h00000200);
        rdiff(12'h048, 32'h00000002);
        wr(12'h400, 32'h00000100);
        wr(12'h04C, 32'h0000FFFF);
        wr(12'h048, 32'hFFFFFFF0);
        wr(12'h040, 32'h00500000);
        rc(12'h048, 32'hFFFFFFF0);
        wr(12'h400, 32'h00000603);
        for (i = 0; i < 40 && pmi_r !== 1'b1; i++) @(negedge clk);
        if (pmi_r !== 1'b1) begin
            n_errors++;
            wrap_up();
        end
        chk("pmi core", 32'h00000003, {28'h0000000, pmi_core_r});
        rc(12'h404, 32'h00000008);
        rc(12'h004, 32'h00000004);
        rc(12'h04C, 32'h00000000);
        rdiff(12'h048, 32'h00000000);
        wr(12'h004, 32'h00000004);
        rc(12'h004, 32'h00000000);
        wr(12'h404, 32'h00000008);
        rc(12'h404, 32'h00000000);
        wr(12'h020, 32'h00000000);
        wr(12'h024, 32'h00000000);
        rc(12'h020, 32'h00000000);
        wr(12'h400, 32'h00000200);
        wr(12'h100, 32'h00000100);
        wr(12'h110, 32'h00400101);
        rc(12'h100, 32'h00000100);
        rdiff(12'h120, 32'h00000000);
        wr(12'h100, 32'h00000000);
        rdiff(12'h120, 32'h00000002);
        wr(12'h200, 32'h00000100);
        rdiff(12'h120, 32'h00000002);
        wr(12'h114, 32'hFFFFFFFF);
        rc(12'h114, 32'hFFD4FFFF);
        wr(12'h100, 32'h00000003);
        rc(12'h110, 32'h00000000);
        rc(12'h114, 32'h00000000);
        rc(12'h120, 32'h00000000);
        wr(12'h108, 32'h000001AB);
        wr(12'h110, 32'h00400101);
        rdiff(12'h120, 32'h00000000);
        box_opcode = 16'h00AB;
        rdiff(12'h120, 32'h00000002);
        // four lines against threshold 3 give one count per cycle, not four
        wr(12'h110, 32'h03400F01);
        rdiff(12'h120, 32'h00000002);
        wr(12'h110, 32'h03C00F01);
        rdiff(12'h120, 32'h00000000);
        wr(12'h120, 32'h00000000);
        wr(12'h110, 32'h03440F01);
        rc(12'h120, 32'h00000001);
        wr(12'h110, 32'h00400101);
        // both counters sit one event from wrap while the box is held
        wr(12'h100, 32'h00000100);
        wr(12'h108, 32'h00000000);
        wr(12'h114, 32'h00400101);
        wr(12'h124, 32'h0000FFFF);
        wr(12'h120, 32'hFFFFFFFF);
        wr(12'h12C, 32'h0000FFFF);
        wr(12'h128, 32'hFFFFFFFF);
        wr(12'h100, 32'h00000000);
        // wrap lands one edge after the release, status one edge later
        @(negedge clk);
        rc(12'h104, 32'h00000003);
        rc(12'h10C, 32'h00000000);
        rc(12'h404, 32'h00000000);
        wrap_up();
    end
endmodule // testbench
